// [core/lswd_hit_decode.sv]
`timescale 1ns/1ps
`include "lswd_map.svh"

module lswd_hit_decode
(
  input wire logic [31:0] base,
  input wire lswd_pkg::lswd_req_type req,
  output lswd_pkg::lswd_dec_type dec
);

  function automatic logic space_mask(input logic [31:0] b,
                                      input lswd_pkg::lswd_space_type s);
    case (s)
      lswd_pkg::lswd_sp_cpu: space_mask = b[`LSWD_CI_BIT];
      lswd_pkg::lswd_sp_sup_code: space_mask = b[`LSWD_SC_BIT];
      lswd_pkg::lswd_sp_sup_data: space_mask = b[`LSWD_SD_BIT];
      lswd_pkg::lswd_sp_user_code: space_mask = b[`LSWD_UC_BIT];
      lswd_pkg::lswd_sp_user_data: space_mask = b[`LSWD_UD_BIT];
      default: space_mask = 1'b1;
    endcase
  endfunction : space_mask

  function automatic logic [3:0] lanes(input lswd_pkg::lswd_size_type sz,
                                       input logic [1:0] a);
    case (sz)
      lswd_pkg::lswd_sz_byte: lanes = `LSWD_BE_BYTE0 >> a;
      lswd_pkg::lswd_sz_word: lanes = a[1] ? `LSWD_BE_LO : `LSWD_BE_HI;
      default: lanes = `LSWD_BE_ALL;
    endcase
  endfunction : lanes

  always_comb
  begin
    dec = '0;
    // Base ignored while valid is clear
    dec.match = base[`LSWD_VALID_BIT] &&
      (req.addr[`LSWD_BASE_MSB:`LSWD_BASE_LSB] ==
       base[`LSWD_BASE_MSB:`LSWD_BASE_LSB]);
    dec.masked = space_mask(base, req.space);
    dec.hit = req.valid && dec.match && !dec.masked;
    dec.wp_block = dec.hit && req.write && base[`LSWD_WP_BIT];
    dec.be = lanes(req.size, req.addr[1:0]);
  end

endmodule : lswd_hit_decode

// [core/lswd_map.svh]
`ifndef LSWD_MAP_SVH
`define LSWD_MAP_SVH

// Control register code of the SRAM base register
`define LSWD_CREG_CODE 12'hc04
// Field positions in the SRAM base register
`define LSWD_VALID_BIT 0
`define LSWD_UD_BIT 1
`define LSWD_UC_BIT 2
`define LSWD_SD_BIT 3
`define LSWD_SC_BIT 4
`define LSWD_CI_BIT 5
`define LSWD_WP_BIT 8
`define LSWD_BASE_LSB 9
`define LSWD_BASE_MSB 31
// Bits 7 and 6 are undefined and always zero
`define LSWD_WMASK 32'hffff_ff3f
`define LSWD_RESET 32'h0000_0000
// Array geometry: 128 words of 32 bits
`define LSWD_WORDS 128
`define LSWD_WORD_AW 7
`define LSWD_WORD_LSB 2
`define LSWD_WORD_MSB 8
// Byte lane patterns, byte 0 on bits 31:24
`define LSWD_BE_ALL 4'hf
`define LSWD_BE_BYTE0 4'h8
`define LSWD_BE_HI 4'hc
`define LSWD_BE_LO 4'h3

`endif

// [core/lswd_mem.sv]
`timescale 1ns/1ps
`include "lswd_map.svh"

module lswd_mem
#(
  parameter int WORDS = `LSWD_WORDS,
  parameter int AW = `LSWD_WORD_AW
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic we,
  input wire logic [3:0] be,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata_r
);

  logic [31:0] mem [WORDS];
  logic [31:0] rdata_nxt;
  wire [3:0] lane_we;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign lane_we[g] = en && we && be[g];
    end
  endgenerate

  // Contents are undefined after reset
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (lane_we[i])
      begin
        mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
      end
    end
  end

  always_comb
  begin
    rdata_nxt = rdata_r;
    if (en && !we)
    begin
      rdata_nxt = mem[addr];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_r <= '0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

endmodule : lswd_mem

// [core/lswd_pkg.sv]
package lswd_pkg;

  typedef enum logic [1:0]
  {
    lswd_sz_long = 2'h0,
    lswd_sz_byte = 2'h1,
    lswd_sz_word = 2'h2,
    lswd_sz_line = 2'h3
  } lswd_size_type;

  typedef enum logic [2:0]
  {
    lswd_sp_cpu = 3'h0,
    lswd_sp_sup_code = 3'h1,
    lswd_sp_sup_data = 3'h2,
    lswd_sp_user_code = 3'h3,
    lswd_sp_user_data = 3'h4
  } lswd_space_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic debug;
    lswd_size_type size;
    lswd_space_type space;
    logic [31:0] addr;
    logic [31:0] wdata;
  } lswd_req_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic supervisor;
    logic from_debug;
    logic [11:0] code;
    logic [31:0] wdata;
  } lswd_creg_type;

  typedef struct packed {
    logic done;
    logic hit;
    logic access_error;
    logic ext_start;
    logic icache_discard;
  } lswd_resp_type;

  typedef struct packed {
    logic match;
    logic masked;
    logic hit;
    logic wp_block;
    logic [3:0] be;
  } lswd_dec_type;

endpackage : lswd_pkg

// [core/lswd_sram_window.sv]
`timescale 1ns/1ps
`include "lswd_map.svh"

// Function
// - Base register written only by privileged control move with code c04.
// - Undefined base register bits ignore writes and read as zero.
// - Normal reads of the write-only register return zero.
// - Base register reads back its contents only in debug halt mode.
// - Reset clears valid and bits 7 and 6.
// - Hit needs address bits 31:9 equal to the base field.
// - Valid clear disables the SRAM; matching requests go external.
// - A set space mask sends that space to an external cycle.
// - Unmasked hits read the array, write only without write protect.
// - Protected writes to the SRAM raise an access error.
// - SRAM supplies mapped fetches and the cache result is discarded.
// - Masked spaces never enable the array, saving power.
// - Array contents undefined after reset, module off until valid set.
// - Debug module may access the SRAM and its base register.
// - Array holds 128 words of 32 bits, base 512-byte aligned.
// - Byte, word and longword accesses complete in one cycle.

module lswd_sram_window
#(
  parameter int WORDS = `LSWD_WORDS,
  parameter int AW = `LSWD_WORD_AW
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire lswd_pkg::lswd_req_type req,
  input wire lswd_pkg::lswd_creg_type creg,
  input wire logic debug_halt_mode,
  output lswd_pkg::lswd_resp_type resp_r,
  output logic [31:0] resp_rdata,
  output logic creg_ack_r,
  output logic [31:0] creg_rdata_r
);

  logic [31:0] sram_base_register_r;
  logic [31:0] sram_base_register_nxt;
  lswd_pkg::lswd_resp_type resp_nxt;
  logic creg_ack_nxt;
  logic [31:0] creg_rdata_nxt;
  lswd_pkg::lswd_dec_type dec;
  logic creg_sel;
  logic mem_en;
  logic mem_we;
  logic served;
  logic is_code;

  lswd_hit_decode u_dec
  (
    .base(sram_base_register_r),
    .req(req),
    .dec(dec)
  );

  lswd_mem
  #(
    .WORDS(WORDS),
    .AW(AW)
  )
  u_mem
  (
    .clk(clk),
    .rst_b(rst_b),
    .en(mem_en),
    .we(mem_we),
    .be(dec.be),
    .addr(req.addr[`LSWD_WORD_MSB:`LSWD_WORD_LSB]),
    .wdata(req.wdata),
    .rdata_r(resp_rdata)
  );

  // Control register move decode
  always_comb
  begin
    creg_sel = creg.valid && (creg.code == `LSWD_CREG_CODE) &&
      (creg.supervisor || creg.from_debug);
  end

  // Base register group
  always_comb
  begin
    sram_base_register_nxt = sram_base_register_r;
    if (creg_sel && creg.write)
    begin
      sram_base_register_nxt = creg.wdata & `LSWD_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sram_base_register_r <= `LSWD_RESET;
    end
    else
    begin
      sram_base_register_r <= sram_base_register_nxt;
    end
  end

  // Control register answer group
  always_comb
  begin
    creg_ack_nxt = creg_sel;
    creg_rdata_nxt = '0;
    if (creg_sel && !creg.write && debug_halt_mode)
    begin
      creg_rdata_nxt = sram_base_register_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      creg_ack_r <= 1'b0;
      creg_rdata_r <= '0;
    end
    else
    begin
      creg_ack_r <= creg_ack_nxt;
      creg_rdata_r <= creg_rdata_nxt;
    end
  end

  // Local bus access group
  always_comb
  begin
    is_code = (req.space == lswd_pkg::lswd_sp_sup_code) ||
      (req.space == lswd_pkg::lswd_sp_user_code);
    served = dec.hit && !dec.wp_block;
    mem_en = served;
    mem_we = served && req.write;
    resp_nxt = '0;
    resp_nxt.done = req.valid;
    resp_nxt.hit = served;
    resp_nxt.access_error = dec.wp_block;
    resp_nxt.ext_start = req.valid && !dec.hit;
    resp_nxt.icache_discard = served && !req.write && is_code;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      resp_r <= '0;
    end
    else
    begin
      resp_r <= resp_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_req_taken;
    req.valid;
  endsequence

  sequence s_prot_write;
    req.valid && req.write && sram_base_register_r[`LSWD_VALID_BIT] &&
      sram_base_register_r[`LSWD_WP_BIT] && dec.match && !dec.masked;
  endsequence

  sequence s_creg_read_run;
    creg_sel && !creg.write && !debug_halt_mode;
  endsequence

  a_super_only: assert property (
    (creg.valid && creg.write && !creg.supervisor && !creg.from_debug)
      |=> $stable(sram_base_register_r))
    else $error("base register changed without privilege");

  a_code_only: assert property (
    (creg.valid && creg.write && creg.code != `LSWD_CREG_CODE)
      |=> $stable(sram_base_register_r))
    else $error("base register changed by another code");

  a_resv_zero: assert property (
    sram_base_register_r[7:6] == 2'h0)
    else $error("undefined base bits not zero");

  a_wo_read: assert property (
    s_creg_read_run |=> (creg_ack_r && creg_rdata_r == 32'h0))
    else $error("run mode read not zero");

  a_halt_read: assert property (
    (creg_sel && !creg.write && debug_halt_mode)
      |=> creg_rdata_r == $past(sram_base_register_r))
    else $error("halted read wrong");

  a_base_match: assert property (
    resp_r.hit |-> ($past(req.addr[31:9]) ==
      $past(sram_base_register_r[31:9])))
    else $error("hit without base match");

  a_invalid_ext: assert property (
    (s_req_taken and !sram_base_register_r[`LSWD_VALID_BIT])
      |=> (resp_r.ext_start && !resp_r.hit))
    else $error("invalid base did not go external");

  a_mask_ext: assert property (
    (s_req_taken and dec.masked) |=> resp_r.ext_start && !resp_r.hit)
    else $error("masked space not external");

  a_wp_error: assert property (
    s_prot_write |=> resp_r.access_error && !resp_r.hit)
    else $error("protected write without error");

  a_wp_nowrite: assert property (
    mem_we |-> !sram_base_register_r[`LSWD_WP_BIT])
    else $error("array written under protection");

  a_fetch_src: assert property (
    (s_req_taken and dec.hit && !req.write && is_code)
      |=> (resp_r.icache_discard && resp_r.hit && !resp_r.ext_start))
    else $error("mapped fetch not taken from SRAM");

  a_idle_mask: assert property (
    mem_en |-> (!dec.masked && req.valid))
    else $error("array enabled for masked space");

  a_one_cycle: assert property (
    s_req_taken |=> resp_r.done ##0
      (resp_r.hit || resp_r.ext_start || resp_r.access_error))
    else $error("access not answered in one cycle");

  a_rd_data: assert property (
    (s_req_taken and served && !req.write) ##1 1'b1
      |-> resp_rdata == u_mem.mem[$past(req.addr[8:2])])
    else $error("read data wrong");

  sequence s_prot_read;
    req.valid && !req.write && sram_base_register_r[`LSWD_WP_BIT] &&
      dec.match && !dec.masked;
  endsequence

  sequence s_full_write;
    req.valid && req.write && served && dec.be == `LSWD_BE_ALL;
  endsequence

  a_base_load: assert property (
    (creg_sel && creg.write)
      |=> sram_base_register_r == ($past(creg.wdata) & `LSWD_WMASK))
    else $error("base register not loaded");

  a_ack_sel: assert property (
    !creg_sel |=> !creg_ack_r)
    else $error("control move answered without select");

  a_read_keep: assert property (
    (creg_sel && !creg.write) |=> $stable(sram_base_register_r))
    else $error("control read changed the base register");

  a_rdata_idle: assert property (
    !(creg_sel && !creg.write && debug_halt_mode)
      |=> creg_rdata_r == 32'h0)
    else $error("control read data not zero");

  a_quiet_idle: assert property (
    !req.valid |=> (resp_r == '0))
    else $error("answer without a request");

  a_one_outcome: assert property (
    resp_r.done |-> $onehot({resp_r.hit, resp_r.ext_start,
      resp_r.access_error}))
    else $error("answer without exactly one outcome");

  a_discard_hit: assert property (
    resp_r.icache_discard |-> resp_r.hit)
    else $error("cache result dropped without SRAM data");

  a_wp_read_ok: assert property (
    s_prot_read |=> (resp_r.hit && !resp_r.access_error))
    else $error("protected read not served");

  a_miss_ext: assert property (
    (s_req_taken and !dec.match) |=> (resp_r.ext_start && !resp_r.hit))
    else $error("address miss not external");

  a_space_undef: assert property (
    (s_req_taken and req.space > lswd_pkg::lswd_sp_user_data)
      |=> resp_r.ext_start)
    else $error("undefined space not external");

  // Protected write leaves the word as it was
  a_wp_keep: assert property (
    s_prot_write |=>
      (u_mem.mem[$past(req.addr[`LSWD_WORD_MSB:`LSWD_WORD_LSB])] ==
       $past(u_mem.mem[req.addr[`LSWD_WORD_MSB:`LSWD_WORD_LSB]])))
    else $error("protected write changed the array");

  a_wr_store: assert property (
    s_full_write |=>
      (u_mem.mem[$past(req.addr[`LSWD_WORD_MSB:`LSWD_WORD_LSB])] ==
       $past(req.wdata)))
    else $error("longword write not stored");

  a_we_hit: assert property (
    mem_we |-> (dec.hit && req.write && !dec.wp_block))
    else $error("array written without a hit");

  a_reset_off: assert property (
    !sram_base_register_r[`LSWD_VALID_BIT] |-> !mem_en)
    else $error("array enabled while base invalid");

endmodule : lswd_sram_window

// [sim/lswd_bus_model.sv]
`timescale 1ns/1ps

module lswd_bus_model
(
  input wire logic clk,
  output lswd_pkg::lswd_req_type req,
  output lswd_pkg::lswd_creg_type creg
);
  initial
  begin
    req = '0;
    creg = '0;
  end

  // Register move from core or debug module
  task automatic move(input logic w, s, g, input logic [11:0] c,
    input logic [31:0] d);
    @(negedge clk);
    creg = '{1'b1, w, s, g, c, d};
    @(negedge clk);
    creg.valid = 1'b0;
    // Released lines must not keep the old value
    creg.wdata = ~d;
  endtask : move

  task automatic bus(input logic w, input logic [1:0] z,
    input logic [2:0] p, input logic [31:0] a, d);
    @(negedge clk);
    req = '{1'b1, w, 1'b0, lswd_pkg::lswd_size_type'(z),
      lswd_pkg::lswd_space_type'(p), a, d};
    @(negedge clk);
    req.valid = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask : bus
endmodule : lswd_bus_model

// [sim/tb.sv]
`timescale 1ns/1ps

module tb;
  typedef struct packed {
    logic [1:0] k;
    logic [2:0] sp;
    logic [1:0] sz;
    logic [31:0] a;
    logic [31:0] d;
    logic [4:0] f;
    logic [31:0] r;
  } lswd_row_type;

  localparam logic [31:0] win = 32'h2000_0000;
  localparam logic [4:0] fh = 5'h18;
  localparam logic [4:0] fd = 5'h19;
  localparam logic [4:0] fx = 5'h12;
  localparam logic [4:0] fe = 5'h14;
  logic clk;
  logic rst_b;
  logic halt;
  lswd_pkg::lswd_req_type req;
  lswd_pkg::lswd_creg_type creg;
  lswd_pkg::lswd_resp_type resp;
  logic [31:0] rdata;
  logic ack;
  logic [31:0] crd;
  int failures;
  int checks_done;
  lswd_row_type rows[$];

  lswd_bus_model core (.clk(clk), .req(req), .creg(creg));

  lswd_sram_window dut (.clk(clk), .rst_b(rst_b), .req(req), .creg(creg),
    .debug_halt_mode(halt), .resp_r(resp), .resp_rdata(rdata),
    .creg_ack_r(ack), .creg_rdata_r(crd));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic cmp_flags(input string n, input logic [4:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_flags

  task automatic cmp_word(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_word

  task automatic mv(input logic w, s, g, h, input logic [11:0] c,
    input logic [31:0] d, input logic a, input logic [31:0] r);
    halt = h;
    core.move(w, s, g, c, d);
    cmp_flags("creg_ack", {4'h0, a}, {4'h0, ack});
    cmp_word("creg_rdata", r, crd);
  endtask : mv

  task automatic run(input lswd_row_type t);
    if (t.k == 2'h0)
      mv(1'b1, 1'b1, 1'b0, 1'b0, 12'hc04, t.d, 1'b1, 32'h0);
    else
    begin
      core.bus(t.k[1], t.sz, t.sp, t.a, t.d);
      cmp_flags("resp", t.f, resp);
      if (!t.k[1] && t.f[3])
        cmp_word("rdata", t.r, rdata);
    end
  endtask : run

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial
  begin
    rst_b = 1'b0;
    halt = 1'b0;
    failures = 0;
    checks_done = 0;
    // Base first, then contents, then attributes
    rows = '{
      '{2'h0, 3'h0, 2'h0, 32'h0, win | 32'h21, 5'h0, 32'h0},
      '{2'h2, 3'h4, 2'h0, win, 32'h1122_3344, fh, 32'h0},
      '{2'h1, 3'h1, 2'h0, win, 32'h0, fd, 32'h1122_3344},
      '{2'h2, 3'h2, 2'h1, win + 1, 32'h00aa_0000, fh, 32'h0},
      '{2'h2, 3'h4, 2'h2, win + 2, 32'h0000_beef, fh, 32'h0},
      '{2'h1, 3'h2, 2'h0, win, 32'h0, fh, 32'h11aa_beef},
      '{2'h2, 3'h2, 2'h0, win + 32'h1fc, 32'hcafe_0001, fh, 32'h0},
      '{2'h1, 3'h3, 2'h0, win + 32'h1fc, 32'h0, fd, 32'hcafe_0001},
      '{2'h1, 3'h4, 2'h0, win, 32'h0, fh, 32'h11aa_beef},
      '{2'h1, 3'h2, 2'h0, win + 32'h200, 32'h0, fx, 32'h0},
      '{2'h1, 3'h0, 2'h0, win, 32'h0, fx, 32'h0},
      '{2'h1, 3'h5, 2'h0, win, 32'h0, fx, 32'h0},
      '{2'h1, 3'h4, 2'h3, win, 32'h0, fh, 32'h11aa_beef},
      '{2'h0, 3'h0, 2'h0, 32'h0, win | 32'h2b, 5'h0, 32'h0},
      '{2'h1, 3'h2, 2'h0, win, 32'h0, fx, 32'h0},
      '{2'h1, 3'h3, 2'h0, win, 32'h0, fd, 32'h11aa_beef},
      '{2'h0, 3'h0, 2'h0, 32'h0, win | 32'h35, 5'h0, 32'h0},
      '{2'h1, 3'h1, 2'h0, win, 32'h0, fx, 32'h0},
      '{2'h1, 3'h4, 2'h0, win, 32'h0, fh, 32'h11aa_beef},
      '{2'h0, 3'h0, 2'h0, 32'h0, win | 32'h20, 5'h0, 32'h0},
      '{2'h1, 3'h2, 2'h0, win, 32'h0, fx, 32'h0},
      '{2'h0, 3'h0, 2'h0, 32'h0, win | 32'h21, 5'h0, 32'h0}
    };
    repeat (16) @(negedge clk);
    cmp_flags("resp", 5'h0, resp);
    rst_b = 1'b1;
    foreach (rows[i])
      run(rows[i]);
    $display("table rows done");
    mv(1'b1, 1'b1, 1'b0, 1'b0, 12'h004, win, 1'b0, 32'h0);
    mv(1'b1, 1'b0, 1'b0, 1'b0, 12'hc04, 32'h0, 1'b0, 32'h0);
    mv(1'b0, 1'b1, 1'b0, 1'b1, 12'hc04, 32'h0, 1'b1, win | 32'h21);
    mv(1'b0, 1'b1, 1'b0, 1'b0, 12'hc04, 32'h0, 1'b1, 32'h0);
    mv(1'b1, 1'b0, 1'b1, 1'b0, 12'hc04, win | 32'h1c1, 1'b1, 32'h0);
    mv(1'b0, 1'b0, 1'b1, 1'b1, 12'hc04, 32'h0, 1'b1, win | 32'h101);
    run('{2'h2, 3'h2, 2'h1, win, 32'h5500_0000, fe, 32'h0});
    run('{2'h1, 3'h2, 2'h0, win, 32'h0, fh, 32'h11aa_beef});
    $display("register and protect tests done");
    rst_b = 1'b0;
    @(negedge clk);
    cmp_flags("resp", 5'h0, resp);
    rst_b = 1'b1;
    mv(1'b0, 1'b1, 1'b0, 1'b1, 12'hc04, 32'h0, 1'b1, 32'h0);
    run('{2'h1, 3'h2, 2'h0, 32'h0, 32'h0, fx, 32'h0});
    $display("second reset test done");
    wrap_up();
  end
endmodule : tb
